// File: dsspt_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dsspt_channel
  import dsspt_pkg::*;
(
  input  wire logic       ref_clk,    // I/O clock
  input  wire logic       reset_n,    // Sync reset
  input  wire logic       match,      // Compare match this tick
  input  wire logic       slope_down, // Match belongs to down slope
  input  wire logic [1:0] action,     // Output action select
  input  wire logic       toggle_ok,  // Toggle allowed for this channel
  output var  logic       oc          // Compare output level
);
  typedef struct packed {
    logic oc;
  } dsspt_ch_state_t;

  dsspt_ch_state_t st;
  dsspt_ch_state_t next_st;

  always_comb begin
    next_st = st;
    if (match) begin
      case (action)
        ACT_TOGGLE: begin
          if (toggle_ok) begin
            next_st.oc = ~st.oc;
          end
        end
        ACT_NONINV: next_st.oc = slope_down;
        ACT_INV:    next_st.oc = ~slope_down;
        default:    next_st.oc = st.oc;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign oc = st.oc;
endmodule
`default_nettype wire

// File: dsspt_load.sv
`timescale 1ns/1ps
`default_nettype none
module dsspt_load (
  input  wire logic ref_clk, // Clock
  input  wire logic clr,     // Restart count
  input  wire logic drv,     // Drive level
  input  wire logic oe,      // Drive enable
  output wire logic lvl,     // Level at load
  output var  int   hi_cnt   // Cycles high
);
  // Load pulls the line low when nobody drives it
  assign lvl = oe ? drv : 1'b0;
  always_ff @(posedge ref_clk) begin
    hi_cnt <= clr ? 0 : hi_cnt + int'(lvl);
  end
endmodule
`default_nettype wire

// File: dsspt_pkg.sv
`default_nettype none
package dsspt_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;

  // Register offsets
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_COUNT   = 3'h1;
  localparam logic [2:0] REG_CMP_A   = 3'h2;
  localparam logic [2:0] REG_CMP_B   = 3'h3;
  localparam logic [2:0] REG_CAP_TOP = 3'h4;
  localparam logic [2:0] REG_FLAGS   = 3'h5;
  localparam logic [2:0] REG_IRQ_EN  = 3'h6;

  // Control register fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_CLKSEL_LSB = 4;
  localparam int CTRL_ACT_A_LSB  = 8;
  localparam int CTRL_ACT_B_LSB  = 10;
  localparam int CTRL_DIR_A_BIT  = 12;
  localparam int CTRL_DIR_B_BIT  = 13;
  localparam int CTRL_DOWN_BIT   = 15;

  // Flag bits
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CAP   = 3;

  // Reset values
  localparam logic [15:0] REG_RST    = 16'h0000;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;
  localparam logic [15:0] BOTTOM     = 16'h0000;

  // Waveform modes
  localparam logic [3:0] MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CMPA  = 4'he;

  // Output actions
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // Clock selects and divider terminal counts
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] LAST_DIV1    = 10'h000;
  localparam logic [9:0] LAST_DIV8    = 10'h007;
  localparam logic [9:0] LAST_DIV64   = 10'h03f;
  localparam logic [9:0] LAST_DIV256  = 10'h0ff;
  localparam logic [9:0] LAST_DIV1024 = 10'h3ff;

  typedef enum logic {DSSPT_UP, DSSPT_DOWN} dsspt_dir_t;

  function automatic logic dsspt_is_dual(input logic [3:0] mode);
    return (mode == MODE_PFC_CAP) || (mode == MODE_PFC_CMPA);
  endfunction

  function automatic logic dsspt_toggle_ok(input logic [3:0] mode);
    return (mode == MODE_PFC_CMPA) || (mode == MODE_PC_CMPA);
  endfunction
endpackage
`default_nettype wire

// File: dsspt_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module dsspt_prescale
  import dsspt_pkg::*;
(
  input  wire logic       ref_clk,  // I/O clock
  input  wire logic       reset_n,  // Sync reset
  input  wire logic [2:0] clk_sel,  // Divider select
  output var  logic       tick      // One-cycle timer tick
);
  typedef struct packed {
    logic [9:0] div_cnt;
    logic       tick;
  } dsspt_pre_state_t;

  dsspt_pre_state_t st;
  dsspt_pre_state_t next_st;
  logic [9:0]       last;

  always_comb begin
    case (clk_sel)
      CS_DIV1:    last = LAST_DIV1;
      CS_DIV8:    last = LAST_DIV8;
      CS_DIV64:   last = LAST_DIV64;
      CS_DIV256:  last = LAST_DIV256;
      CS_DIV1024: last = LAST_DIV1024;
      default:    last = LAST_DIV1;
    endcase
    next_st = st;
    if (clk_sel == CS_STOP || clk_sel > CS_DIV1024) begin
      next_st.div_cnt = '0;
      next_st.tick = 1'b0;
    end else if (st.div_cnt >= last) begin
      next_st.div_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 10'h001;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

// File: dsspt_props.sv
`timescale 1ns/1ps
`default_nettype none
module dsspt_props
  import dsspt_pkg::*;
(
  input wire logic [ADDR_W-1:0] reg_addr,    // Addr
  input wire logic [DATA_W-1:0] reg_wdata,   // Wdata
  input wire logic              reg_wr,      // Write
  input wire logic              reg_rd,      // Read
  input wire logic [DATA_W-1:0] reg_rdata,   // Rdata
  input wire logic              ref_clk,     // Clock
  input wire logic              reset_n,     // Reset
  input wire logic              port_data_a, // Port A
  input wire logic              port_data_b, // Port B
  input wire logic              pin_out_a,   // Pin A
  input wire logic              pin_oe_a,    // Enable A
  input wire logic              pin_out_b,   // Pin B
  input wire logic              pin_oe_b,    // Enable B
  input wire logic              irq_req      // Irq
);
  logic [15:0] ctl;
  logic        en0, wr_ctl, off_a, off_b;
  logic [2:0]  qt, sc;
  assign wr_ctl = reg_wr && reg_addr == REG_CTRL;
  assign off_a  = ctl[9:8] == ACT_OFF || (ctl[9:8] == ACT_TOGGLE && ctl[3:0] != MODE_PFC_CMPA
                  && ctl[3:0] != MODE_PC_CMPA);
  assign off_b  = ctl[11:10] == ACT_OFF || ctl[11:10] == ACT_TOGGLE;
  // Saturating counters: a pending tick may still land just after a stop
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctl <= 16'h0000;
      en0 <= 1'b1;
      qt  <= 3'h0;
      sc  <= 3'h0;
    end else begin
      ctl <= wr_ctl ? reg_wdata : ctl;
      en0 <= (reg_wr && reg_addr == REG_IRQ_EN) ? reg_wdata[3:0] == 4'h0 : en0;
      qt  <= (reg_wr || ctl[6:4] != CS_STOP) ? 3'h0 : qt + {2'h0, qt != 3'h7};
      sc  <= wr_ctl ? 3'h0 : sc + {2'h0, sc != 3'h7};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_oe_a;
    wr_ctl |-> ##2 pin_oe_a == $past(reg_wdata[CTRL_DIR_A_BIT], 2);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("enable A wrong");
  property p_oe_b;
    wr_ctl |-> ##2 pin_oe_b == $past(reg_wdata[CTRL_DIR_B_BIT], 2);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("enable B wrong");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_void;
    reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_void: assert property (p_rd_void) else $error("unmapped read data");
  property p_irq_off;
    en0 && $past(en0) && $past(en0, 2) |-> !irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_stop;
    qt == 3'h7 |-> $stable(irq_req);
  endproperty
  a_stop: assert property (p_stop) else $error("irq moved while stopped");
  property p_port_a;
    off_a && sc == 3'h7 && $stable(port_data_a) && port_data_a == $past(port_data_a, 2)
      && port_data_a == $past(port_data_a, 3) |-> pin_out_a == port_data_a;
  endproperty
  a_port_a: assert property (p_port_a) else $error("pin A not port");
  property p_port_b;
    off_b && sc == 3'h7 && $stable(port_data_b) && port_data_b == $past(port_data_b, 2)
      && port_data_b == $past(port_data_b, 3) |-> pin_out_b == port_data_b;
  endproperty
  a_port_b: assert property (p_port_b) else $error("pin B not port");
endmodule
bind dsspt_top dsspt_props dsspt_props_i (.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ref_clk, .reset_n, .port_data_a, .port_data_b, .pin_out_a, .pin_oe_a, .pin_out_b, .pin_oe_b, .irq_req);
`default_nettype wire

// File: dsspt_top.sv
// What this block does
// - Modes 8 and 9 count 0 up to TOP, down to 0, repeating.
// - Non-inverting clears on up-count match, sets on down; inverting reversed.
// - TOP comes from capture/top in mode 8, compare A in mode 9.
// - Counter holds TOP for exactly one tick before counting down.
// - Channel flag sets whenever counter equals its active compare value.
// - Overflow flag sets at BOTTOM, same tick compares load from buffers.
// - Compare A or capture flag sets on reaching TOP, per TOP source.
// - Compare above TOP never matches; software keeps TOP above compares.
// - Action 2 gives non-inverted PWM, action 3 inverted.
// - Waveform reaches pin only when pin direction bit selects output.
// - Tick divides clock by 1, 8, 64, 256 or 1024.
// - Compare at BOTTOM holds output low, at TOP high; inverted opposite.
// - Mode 9 with action 1 toggles output A each match.
// - Written compares go to a buffer, copied to active at BOTTOM.
// - Counter fully synchronous; tick is only a clock enable.
// - Action 1 toggles A only in modes 9 or 14; B disconnected.
// - Action 0 disconnects output; pin keeps normal port function.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dsspt_top
  import dsspt_pkg::*;
(
  input  wire logic [ADDR_W-1:0] reg_addr,      // Register address
  input  wire logic [DATA_W-1:0] reg_wdata,     // Write data
  input  wire logic              reg_wr,        // Write strobe
  input  wire logic              reg_rd,        // Read strobe
  output var  logic [DATA_W-1:0] reg_rdata,     // Read data, cycle after strobe
  input  wire logic              ref_clk,       // I/O clock
  input  wire logic              reset_n,       // Sync reset
  input  wire logic              port_data_a,   // Normal port value, pin A
  input  wire logic              port_data_b,   // Normal port value, pin B
  output var  logic              pin_out_a,     // Pin A drive level
  output var  logic              pin_oe_a,      // Pin A output enable
  output var  logic              pin_out_b,     // Pin B drive level
  output var  logic              pin_oe_b,      // Pin B output enable
  output var  logic              irq_req        // Interrupt request level
);
  typedef struct packed {
    logic [3:0]  mode;
    logic [2:0]  clk_sel;
    logic [1:0]  act_a;
    logic [1:0]  act_b;
    logic        dir_a;
    logic        dir_b;
    logic [15:0] cnt;
    dsspt_dir_t  cnt_dir;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap_top;
    logic [3:0]  flags;
    logic [3:0]  irq_en;
    logic [15:0] rdata;
    logic        irq;
    logic        pin_out_a;
    logic        pin_oe_a;
    logic        pin_out_b;
    logic        pin_oe_b;
  } dsspt_top_state_t;

  dsspt_top_state_t st;
  dsspt_top_state_t next_st;

  logic        tick;
  logic        oc_a;
  logic        oc_b;
  logic        run;
  logic [15:0] top_val;
  logic        at_top;
  logic        at_bottom;
  logic        slope_down;
  logic [15:0] eff_cmp_a;
  logic [15:0] eff_cmp_b;
  logic        match_a;
  logic        match_b;
  logic        conn_a;
  logic        conn_b;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_cmp_a;
  logic        wr_cmp_b;
  logic        wr_cap_top;
  logic        wr_irq_en;
  logic        wr_flags;

  // Control word as read back, count-down status included
  function automatic logic [15:0] ctrl_word(input dsspt_top_state_t s);
    logic [15:0] w;
    w = '0;
    w[CTRL_MODE_LSB +: 4] = s.mode;
    w[CTRL_CLKSEL_LSB +: 3] = s.clk_sel;
    w[CTRL_ACT_A_LSB +: 2] = s.act_a;
    w[CTRL_ACT_B_LSB +: 2] = s.act_b;
    w[CTRL_DIR_A_BIT] = s.dir_a;
    w[CTRL_DIR_B_BIT] = s.dir_b;
    w[CTRL_DOWN_BIT] = (s.cnt_dir == DSSPT_DOWN);
    return w;
  endfunction

  dsspt_prescale u_prescale (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_sel (st.clk_sel),
    .tick    (tick)
  );

  dsspt_channel u_chan_a (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .match      (match_a),
    .slope_down (slope_down),
    .action     (st.act_a),
    .toggle_ok  (dsspt_toggle_ok(st.mode)),
    .oc         (oc_a)
  );

  // Channel B never toggles
  dsspt_channel u_chan_b (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .match      (match_b),
    .slope_down (slope_down),
    .action     (st.act_b),
    .toggle_ok  (1'b0),
    .oc         (oc_b)
  );

  // Counter, compare and flag events, all qualified by the tick
  always_comb begin
    run = tick && dsspt_is_dual(st.mode);
    top_val = (st.mode == MODE_PFC_CMPA) ? st.cmp_a : st.cap_top;
    // TOP held one tick while still marked up-counting
    at_top = (st.cnt_dir == DSSPT_UP) && (st.cnt >= top_val);
    at_bottom = (st.cnt_dir == DSSPT_DOWN) && (st.cnt == BOTTOM);
    // Match at TOP acts as down slope, at BOTTOM as up slope
    if (at_top) begin
      slope_down = 1'b1;
    end else if (at_bottom) begin
      slope_down = 1'b0;
    end else begin
      slope_down = (st.cnt_dir == DSSPT_DOWN);
    end
    // New buffered value already counts in the loading tick
    eff_cmp_a = at_bottom ? st.buf_a : st.cmp_a;
    eff_cmp_b = at_bottom ? st.buf_b : st.cmp_b;
    // A compare above TOP is never equal to the count
    match_a = run && (st.cnt == eff_cmp_a);
    match_b = run && (st.cnt == eff_cmp_b);
    flag_set = '0;
    flag_set[FLAG_OVF] = run && at_bottom;
    flag_set[FLAG_CMP_A] = match_a || (run && at_top && st.mode == MODE_PFC_CMPA);
    flag_set[FLAG_CMP_B] = match_b;
    flag_set[FLAG_CAP] = run && at_top && (st.mode == MODE_PFC_CAP);
  end

  // Output connection to pins
  always_comb begin
    conn_a = (st.act_a == ACT_NONINV) || (st.act_a == ACT_INV);
    if (st.act_a == ACT_TOGGLE) begin
      conn_a = dsspt_toggle_ok(st.mode);
    end
    conn_b = (st.act_b == ACT_NONINV) || (st.act_b == ACT_INV);
  end

  // Register bus decode
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wr_count = reg_wr && (reg_addr == REG_COUNT);
    wr_cmp_a = reg_wr && (reg_addr == REG_CMP_A);
    wr_cmp_b = reg_wr && (reg_addr == REG_CMP_B);
    wr_cap_top = reg_wr && (reg_addr == REG_CAP_TOP);
    wr_irq_en = reg_wr && (reg_addr == REG_IRQ_EN);
    wr_flags = reg_wr && (reg_addr == REG_FLAGS);
    flag_clr = '0;
    if (wr_flags) begin
      flag_clr = reg_wdata[3:0];
    end
  end

  always_comb begin
    next_st = st;

    if (wr_ctrl) begin
      next_st.mode = reg_wdata[CTRL_MODE_LSB +: 4];
      next_st.clk_sel = reg_wdata[CTRL_CLKSEL_LSB +: 3];
      next_st.act_a = reg_wdata[CTRL_ACT_A_LSB +: 2];
      next_st.act_b = reg_wdata[CTRL_ACT_B_LSB +: 2];
      next_st.dir_a = reg_wdata[CTRL_DIR_A_BIT];
      next_st.dir_b = reg_wdata[CTRL_DIR_B_BIT];
    end
    if (wr_cmp_a) begin
      next_st.buf_a = reg_wdata;
    end
    if (wr_cmp_b) begin
      next_st.buf_b = reg_wdata;
    end
    if (wr_cap_top) begin
      // Takes effect at once, so only safe for a fixed TOP
      next_st.cap_top = reg_wdata;
    end
    if (wr_irq_en) begin
      next_st.irq_en = reg_wdata[3:0];
    end

    // Dual-slope count
    if (run) begin
      if (at_top) begin
        next_st.cnt_dir = DSSPT_DOWN;
        next_st.cnt = st.cnt - 16'h0001;
      end else if (at_bottom) begin
        next_st.cnt_dir = DSSPT_UP;
        next_st.cnt = st.cnt + 16'h0001;
        next_st.cmp_a = st.buf_a;
        next_st.cmp_b = st.buf_b;
      end else if (st.cnt_dir == DSSPT_UP) begin
        next_st.cnt = st.cnt + 16'h0001;
      end else begin
        next_st.cnt = st.cnt - 16'h0001;
      end
    end
    // Outside dual-slope modes the buffers pass straight through
    if (!dsspt_is_dual(st.mode)) begin
      next_st.cmp_a = st.buf_a;
      next_st.cmp_b = st.buf_b;
    end
    // Software write to the count wins over counting
    if (wr_count) begin
      next_st.cnt = reg_wdata;
    end

    // Set wins over a clear in the same cycle
    next_st.flags = (st.flags & ~flag_clr) | flag_set;
    next_st.irq = |(next_st.flags & next_st.irq_en);

    // Read data stands only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:    next_st.rdata = ctrl_word(st);
        REG_COUNT:   next_st.rdata = st.cnt;
        REG_CMP_A:   next_st.rdata = st.buf_a;
        REG_CMP_B:   next_st.rdata = st.buf_b;
        REG_CAP_TOP: next_st.rdata = st.cap_top;
        REG_FLAGS:   next_st.rdata[3:0] = st.flags;
        REG_IRQ_EN:  next_st.rdata[3:0] = st.irq_en;
        default:     next_st.rdata = '0;
      endcase
    end

    // Pin drive; disconnected pins keep their port value
    next_st.pin_out_a = conn_a ? oc_a : port_data_a;
    next_st.pin_out_b = conn_b ? oc_b : port_data_b;
    next_st.pin_oe_a = st.dir_a;
    next_st.pin_oe_b = st.dir_b;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.cnt <= BOTTOM;
      st.cnt_dir <= DSSPT_UP;
      // Clock stopped so nothing moves until software starts it
      st.clk_sel <= CS_STOP;
      st.buf_a <= REG_RST;
      st.buf_b <= REG_RST;
      st.cmp_a <= REG_RST;
      st.cmp_b <= REG_RST;
      st.cap_top <= REG_RST;
      st.flags <= FLAGS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pin_out_a = st.pin_out_a;
  assign pin_oe_a = st.pin_oe_a;
  assign pin_out_b = st.pin_out_b;
  assign pin_oe_b = st.pin_oe_b;
  assign irq_req = st.irq;
endmodule
`default_nettype wire

// File: tb_dsspt_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsspt_top;
  import dsspt_pkg::*;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic        reg_wr, reg_rd, ref_clk, reset_n, port_data_a, port_data_b, clr, lvl_a, lvl_b;
  logic        pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, irq_req;
  int          hi_a, hi_b, n_fail, total_checks, t;
  localparam logic [2:0] cs_tab [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
  localparam int         div_tab [5] = '{1, 8, 64, 256, 1024};
  dsspt_top dsspt_top_i (.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_clk, .reset_n,
    .port_data_a, .port_data_b, .pin_out_a, .pin_oe_a, .pin_out_b, .pin_oe_b, .irq_req);
  dsspt_load load_a (.ref_clk, .clr, .drv(pin_out_a), .oe(pin_oe_a), .lvl(lvl_a), .hi_cnt(hi_a));
  dsspt_load load_b (.ref_clk, .clr, .drv(pin_out_b), .oe(pin_oe_b), .lvl(lvl_b), .hi_cnt(hi_b));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  // High ticks over two output periods at the pin
  function automatic int ticks_hi(input logic [1:0] act, input logic tg, input logic [15:0] c, tp,
                                  input logic p);
    case (act)
      ACT_NONINV: return 4 * c;
      ACT_INV:    return 4 * (tp - c);
      ACT_TOGGLE: return tg ? 2 * tp : 4 * tp * p;
      default:    return 4 * tp * p;
    endcase
  endfunction
  task automatic run(input logic [3:0] m, input int k, input logic [1:0] aa, ab, dr,
                     input logic [15:0] tp, ca, cb);
    logic [15:0] pv, e;
    logic        tg, up;
    int          n;
    n = div_tab[k];
    tg = m == MODE_PFC_CMPA;
    pv = 16'h0000;
    up = 1'b1;
    if (tg) ca = tp;
    wr(REG_CTRL, 16'h0000);
    wr(REG_COUNT, 16'h0000);
    wr(REG_CMP_A, ca);
    wr(REG_CMP_B, cb);
    wr(REG_CAP_TOP, tp);
    port_data_a <= 1'($urandom);
    port_data_b <= 1'($urandom);
    wr(REG_CTRL, {2'h0, dr, ab, aa, 1'b0, cs_tab[k], m});
    repeat (tp * n) begin
      rd(REG_COUNT, v);
      if (n == 8 && v !== pv) begin
        e = up ? (pv == tp ? tp - 16'h0001 : pv + 16'h0001) : (pv == 16'h0000 ? 16'h0001 : pv - 16'h0001);
        chk("count", v, e);
        up = e > pv;
        pv = v;
      end
    end
    wr(REG_FLAGS, 16'h000f);
    repeat (2 * tp * n + 8) @(posedge ref_clk);
    rd(REG_FLAGS, v);
    chk("flags", v, {12'h000, m == MODE_PFC_CAP, cb <= tp, ca <= tp, 1'b1});
    wr(REG_IRQ_EN, 16'h0001);
    repeat (2) @(negedge ref_clk);
    chk("irq", irq_req, 1);
    wr(REG_IRQ_EN, 16'h0000);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (4 * tp * n) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pin_a", hi_a, dr[0] ? n * ticks_hi(aa, tg, ca, tp, port_data_a) : 0);
    chk("pin_b", hi_b, dr[1] ? n * ticks_hi(ab, 1'b0, cb, tp, port_data_b) : 0);
  endtask
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reset_n = 1'b0;
    port_data_a = 1'b0;
    port_data_b = 1'b0;
    clr = 1'b0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(46));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(3'h7, 16'hffff);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk("reset", v, 0);
    end
    run(MODE_PFC_CAP, 1, ACT_NONINV, ACT_INV, 2'h3, 16'h0003, 16'h0000, 16'h0003);
    run(MODE_PFC_CMPA, 1, ACT_TOGGLE, ACT_OFF, 2'h3, 16'h000a, 16'h0000, 16'h000b);
    run(MODE_PFC_CMPA, 1, ACT_NONINV, ACT_NONINV, 2'h1, 16'h000a, 16'h0000, 16'h000a);
    for (int k = 0; k < 5; k++) begin
      run(MODE_PFC_CAP, k, ACT_NONINV, ACT_INV, 2'h3, 16'h0003, 16'h0001, 16'h0002);
    end
    repeat (10) begin
      t = 3 + $urandom % 18;
      run($urandom % 2 ? MODE_PFC_CMPA : MODE_PFC_CAP, 1, 2'($urandom), 2'($urandom), 2'($urandom),
          16'(t), 16'($urandom % (t + 1)), 16'($urandom % (t + 1)));
    end
    wr(REG_CTRL, 16'h0000);
    repeat (8) @(posedge ref_clk);
    wr(REG_FLAGS, 16'h000f);
    wr(REG_IRQ_EN, 16'h000f);
    repeat (3) @(negedge ref_clk);
    chk("irq", irq_req, 0);
    rd(REG_FLAGS, v);
    chk("flags", v, 0);
    wr(REG_IRQ_EN, 16'h0000);
    repeat (10) @(posedge ref_clk);
    results;
  end
  initial begin
    #8_000_000;
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
